// *** core/asc_ctrl.sv ***
// Host controller driving a 2k x 8 asynchronous static memory
// What this block does
// R1: Addresses 2048 words of 8 bits over an 11-bit address and 8-bit bus.
// R2: With chip select high the memory floats its pins and ignores the rest.
// R3: Reads hold write enable high with select and output enable low.
// R4: Read data is sampled no sooner than the access time after the address.
// R5: A write happens only while select and write enable are both low.
// R6: The write pulse meets its least width between the two strobes.
// R7: Write data stands from the start of the pulse until after its rising edge.
// R8: With output enable high during a write the memory never drives.
// R9: Select falling with or after write enable keeps the memory quiet.
// R10: Select rising with or before write enable keeps the pins floating.
// R11: The memory holds old data briefly after an address change.
// R12: The memory starts driving no sooner than its turn-on delay.
// R13: On deselect the memory floats within its float time.
// R14: Select goes high before retention and stays high through it.
// R15: Select low with both enables high leaves the memory idle.
// R16: A read presents the word at the current address.
`timescale 1ns/1ps
module asc_ctrl (
    // Clock and reset
    input  wire logic                      i_core_clk,
    input  wire logic                      i_sys_rst,
    // User request
    input  wire logic                      i_req_valid,
    input  wire asc_pkg::asc_req_t         i_req,
    output logic                           o_req_ready,
    // User response
    output logic                           o_rsp_valid,
    output logic [asc_pkg::DATA_W-1:0]     o_rsp_rdata,
    // Retention hand-off
    input  wire logic                      i_retain_req,
    output logic                           o_retain_ok,
    // Memory control pins
    output asc_pkg::asc_pins_t             o_sram,
    // Memory data pins
    input  wire logic [asc_pkg::DATA_W-1:0] i_data_pins,
    output logic [asc_pkg::DATA_W-1:0]     o_data_pins,
    output logic                           o_data_pins_oe
);

    asc_pkg::asc_state_t          state_ff;
    asc_pkg::asc_state_t          nxt_state;
    logic                         low_supply_ff;
    logic                         write_ff;
    logic                         req_take;
    logic                         tmr_load;
    logic [asc_pkg::CNT_W-1:0]    tmr_value;
    logic                         tmr_expired;
    logic                         req_ready_ff;
    logic                         rsp_valid_ff;
    logic [asc_pkg::DATA_W-1:0]   rsp_rdata_ff;
    logic                         retain_ok_ff;
    asc_pkg::asc_pins_t           sram_ff;
    logic [asc_pkg::DATA_W-1:0]   data_out_ff;
    logic                         data_oe_ff;

    // Pick the 5V or 3V figure for the requested or latched supply
    function automatic logic [asc_pkg::CNT_W-1:0] pick_cyc(
        input logic                      low,
        input logic [asc_pkg::CNT_W-1:0] cyc_5v,
        input logic [asc_pkg::CNT_W-1:0] cyc_3v
    );
        return low ? cyc_3v : cyc_5v;
    endfunction : pick_cyc

    assign req_take = i_req_valid && req_ready_ff && !i_retain_req;

    asc_timer u_timer (
        .i_core_clk (i_core_clk),
        .i_sys_rst  (i_sys_rst),
        .i_load     (tmr_load),
        .i_value    (tmr_value),
        .o_expired  (tmr_expired)
    );

    // Next state and phase timer loads
    always_comb begin
        nxt_state = state_ff;
        tmr_load  = 1'b0;
        tmr_value = '0;
        case (state_ff)
            asc_pkg::ST_IDLE: begin
                if (i_retain_req) begin
                    nxt_state = asc_pkg::ST_RETAIN; // [R14]
                end else if (req_take && !i_req.write) begin
                    nxt_state = asc_pkg::ST_RD_ACC;
                    tmr_load  = 1'b1;
                    tmr_value = pick_cyc(i_req.low_supply,
                                         asc_pkg::ACC_5V_CYC,
                                         asc_pkg::ACC_3V_CYC); // [R4]
                end else if (req_take) begin
                    nxt_state = asc_pkg::ST_WR_SETUP;
                end
            end
            asc_pkg::ST_RD_ACC: begin
                if (tmr_expired) begin
                    nxt_state = asc_pkg::ST_RD_FLOAT;
                    tmr_load  = 1'b1;
                    tmr_value = pick_cyc(low_supply_ff,
                                         asc_pkg::FLOAT_5V_CYC,
                                         asc_pkg::FLOAT_3V_CYC); // [R13]
                end
            end
            asc_pkg::ST_RD_FLOAT: begin
                if (tmr_expired) begin
                    nxt_state = asc_pkg::ST_IDLE;
                end
            end
            asc_pkg::ST_WR_SETUP: begin
                nxt_state = asc_pkg::ST_WR_PULSE;
                tmr_load  = 1'b1;
                tmr_value = pick_cyc(low_supply_ff,
                                     asc_pkg::WP_5V_CYC,
                                     asc_pkg::WP_3V_CYC); // [R6]
            end
            asc_pkg::ST_WR_PULSE: begin
                if (tmr_expired) begin
                    nxt_state = asc_pkg::ST_WR_RECOV;
                    tmr_load  = 1'b1;
                    tmr_value = pick_cyc(low_supply_ff,
                                         asc_pkg::WR_5V_CYC,
                                         asc_pkg::WR_3V_CYC); // [R7]
                end
            end
            asc_pkg::ST_WR_RECOV: begin
                if (tmr_expired) begin
                    nxt_state = asc_pkg::ST_IDLE;
                end
            end
            asc_pkg::ST_RETAIN: begin
                if (!i_retain_req) begin
                    nxt_state = asc_pkg::ST_IDLE;
                end
            end
            default: begin
                nxt_state = asc_pkg::ST_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            state_ff <= asc_pkg::ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Request latch
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            low_supply_ff <= 1'b0;
            write_ff      <= 1'b0;
            data_out_ff   <= asc_pkg::DATA_RST;
        end else if (req_take) begin
            low_supply_ff <= i_req.low_supply;
            write_ff      <= i_req.write;
            data_out_ff   <= i_req.wdata; // [R7]
        end
    end

    // Memory control pins
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            sram_ff.chip_sel_n   <= asc_pkg::PIN_IDLE; // [R2]
            sram_ff.out_en_n     <= asc_pkg::PIN_IDLE;
            sram_ff.wr_en_n      <= asc_pkg::PIN_IDLE;
            sram_ff.word_address <= asc_pkg::ADDR_RST;
        end else begin
            case (nxt_state)
                asc_pkg::ST_RD_ACC: begin
                    if (state_ff == asc_pkg::ST_IDLE) begin
                        sram_ff.word_address <= i_req.word_address; // [R1]
                    end
                    sram_ff.chip_sel_n <= 1'b0; // [R3]
                    sram_ff.out_en_n   <= 1'b0; // [R16]
                    sram_ff.wr_en_n    <= 1'b1; // [R3]
                end
                asc_pkg::ST_WR_SETUP: begin
                    sram_ff.word_address <= i_req.word_address; // [R1]
                    sram_ff.chip_sel_n   <= 1'b0;
                    sram_ff.out_en_n     <= 1'b1; // [R8]
                    sram_ff.wr_en_n      <= 1'b1; // [R15]
                end
                asc_pkg::ST_WR_PULSE: begin
                    sram_ff.chip_sel_n <= 1'b0;
                    sram_ff.out_en_n   <= 1'b1;
                    sram_ff.wr_en_n    <= 1'b0; // [R5]
                end
                asc_pkg::ST_WR_RECOV: begin
                    sram_ff.chip_sel_n <= 1'b0;
                    sram_ff.out_en_n   <= 1'b1;
                    sram_ff.wr_en_n    <= 1'b1; // [R7]
                end
                default: begin
                    sram_ff.chip_sel_n <= 1'b1; // [R2] [R14]
                    sram_ff.out_en_n   <= 1'b1;
                    sram_ff.wr_en_n    <= 1'b1;
                end
            endcase
        end
    end

    // Data bus drive, only while select is low and output enable high
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            data_oe_ff <= 1'b0;
        end else begin
            data_oe_ff <= (nxt_state == asc_pkg::ST_WR_PULSE) ||
                          (nxt_state == asc_pkg::ST_WR_RECOV); // [R8] [R9]
        end
    end

    // Read capture and response
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            rsp_rdata_ff <= asc_pkg::DATA_RST;
            rsp_valid_ff <= 1'b0;
        end else begin
            if (state_ff == asc_pkg::ST_RD_ACC && tmr_expired) begin
                rsp_rdata_ff <= i_data_pins; // [R4] [R11] [R16]
            end
            rsp_valid_ff <= (nxt_state == asc_pkg::ST_IDLE) &&
                            ((state_ff == asc_pkg::ST_RD_FLOAT) ||
                             (state_ff == asc_pkg::ST_WR_RECOV)); // [R13]
        end
    end

    // Ready and retention status
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            req_ready_ff <= 1'b0;
            retain_ok_ff <= 1'b0;
        end else begin
            req_ready_ff <= (nxt_state == asc_pkg::ST_IDLE);
            retain_ok_ff <= (nxt_state == asc_pkg::ST_RETAIN); // [R14]
        end
    end

    assign o_req_ready    = req_ready_ff;
    assign o_rsp_valid    = rsp_valid_ff;
    assign o_rsp_rdata    = rsp_rdata_ff;
    assign o_retain_ok    = retain_ok_ff;
    assign o_sram         = sram_ff;
    assign o_data_pins    = data_out_ff;
    assign o_data_pins_oe = data_oe_ff;

endmodule : asc_ctrl

// *** common/asc_pkg.sv ***
// Constants and carrier types for the 2k x 8 static memory controller
package asc_pkg;

    localparam int ADDR_W = 11;
    localparam int DATA_W = 8;
    localparam int WORDS  = 2048;
    localparam int CNT_W  = 4;

    // Clock period in ns
    localparam int CLK_PERIOD_NS = 20;

    // Memory timing in ns, 5V and 3V figures
    localparam int ACC_5V_NS   = 100;
    localparam int ACC_3V_NS   = 250;
    localparam int FLOAT_5V_NS = 35;
    localparam int FLOAT_3V_NS = 100;
    localparam int WP_5V_NS    = 75;
    localparam int WP_3V_NS    = 190;
    localparam int DS_5V_NS    = 40;
    localparam int DS_3V_NS    = 100;
    localparam int WR_5V_NS    = 10;
    localparam int WR_3V_NS    = 25;

    // Least cycles covering a time, never below one
    function automatic int cyc_min(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : cyc_min

    // Larger of two cycle counts
    function automatic int cyc_max(input int a, input int b);
        return (a > b) ? a : b;
    endfunction : cyc_max

    localparam logic [CNT_W-1:0] ACC_5V_CYC   = CNT_W'(cyc_min(ACC_5V_NS));
    localparam logic [CNT_W-1:0] ACC_3V_CYC   = CNT_W'(cyc_min(ACC_3V_NS));
    localparam logic [CNT_W-1:0] FLOAT_5V_CYC = CNT_W'(cyc_min(FLOAT_5V_NS));
    localparam logic [CNT_W-1:0] FLOAT_3V_CYC = CNT_W'(cyc_min(FLOAT_3V_NS));
    localparam logic [CNT_W-1:0] WP_5V_CYC    =
        CNT_W'(cyc_max(cyc_min(WP_5V_NS), cyc_min(DS_5V_NS)));
    localparam logic [CNT_W-1:0] WP_3V_CYC    =
        CNT_W'(cyc_max(cyc_min(WP_3V_NS), cyc_min(DS_3V_NS)));
    localparam logic [CNT_W-1:0] WR_5V_CYC    = CNT_W'(cyc_min(WR_5V_NS));
    localparam logic [CNT_W-1:0] WR_3V_CYC    = CNT_W'(cyc_min(WR_3V_NS));

    // Idle levels of the memory pins
    localparam logic              PIN_IDLE     = 1'b1;
    localparam logic [ADDR_W-1:0] ADDR_RST     = 11'h000;
    localparam logic [DATA_W-1:0] DATA_RST     = 8'h00;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RD_ACC,
        ST_RD_FLOAT,
        ST_WR_SETUP,
        ST_WR_PULSE,
        ST_WR_RECOV,
        ST_RETAIN
    } asc_state_t;

    // User request
    typedef struct packed {
        logic              write;
        logic              low_supply;
        logic [ADDR_W-1:0] word_address;
        logic [DATA_W-1:0] wdata;
    } asc_req_t;

    // Memory control pins, all active low except the address
    typedef struct packed {
        logic              chip_sel_n;
        logic              out_en_n;
        logic              wr_en_n;
        logic [ADDR_W-1:0] word_address;
    } asc_pins_t;

endpackage : asc_pkg

// *** core/asc_timer.sv ***
// Down counter that times the access, float, write pulse and recovery phases
`timescale 1ns/1ps
module asc_timer (
    // Clock and reset
    input  wire logic                     i_core_clk,
    input  wire logic                     i_sys_rst,
    // Load and status
    input  wire logic                     i_load,
    input  wire logic [asc_pkg::CNT_W-1:0] i_value,
    output logic                          o_expired
);

    logic [asc_pkg::CNT_W-1:0] cnt_ff;

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            cnt_ff <= '0;
        end else if (i_load) begin
            cnt_ff <= i_value;
        end else if (cnt_ff != '0) begin
            cnt_ff <= cnt_ff - 1'b1;
        end
    end

    assign o_expired = (cnt_ff == '0);

endmodule : asc_timer

// *** test/asc_ctrl_props.sv ***
// Concurrent checks on the memory controller ports
`timescale 1ns/1ps
module asc_ctrl_props (
    // Clock and reset
    input wire logic                       i_core_clk,
    input wire logic                       i_sys_rst,
    // Controller outputs
    input wire logic                       o_req_ready,
    input wire logic                       o_rsp_valid,
    input wire logic                       o_retain_ok,
    input wire asc_pkg::asc_pins_t         o_sram,
    input wire logic [asc_pkg::DATA_W-1:0] o_data_pins,
    input wire logic                       o_data_pins_oe
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_sys_rst);
    sequence rd_start; $fell(o_sram.out_en_n); endsequence
    sequence wr_start; $fell(o_sram.wr_en_n); endsequence
    drive_write_a: assert property (o_data_pins_oe |->
        !o_sram.chip_sel_n && o_sram.out_en_n) else $error("drive outside write");
    read_strobes_a: assert property (!o_sram.out_en_n |->
        o_sram.wr_en_n && !o_sram.chip_sel_n) else $error("bad read strobes");
    sel_first_a: assert property (wr_start |->
        $past(o_sram.chip_sel_n) == 1'b0) else $error("select late");
    pulse_width_a: assert property (wr_start |->
        (!o_sram.wr_en_n && o_data_pins_oe)[*4]) else $error("short pulse");
    data_hold_a: assert property ($rose(o_sram.wr_en_n) |->
        !o_sram.chip_sel_n && o_data_pins_oe && $stable(o_data_pins))
        else $error("write end broken");
    access_time_a: assert property (rd_start |-> ##1
        ($stable(o_sram.word_address) && !o_sram.out_en_n)[*4])
        else $error("read too short");
    float_gap_a: assert property ($rose(o_sram.out_en_n) |->
        o_sram.chip_sel_n[*2]) else $error("float gap short");
    retain_park_a: assert property (o_retain_ok |->
        o_sram.chip_sel_n && !o_req_ready) else $error("retain not parked");
    standby_quiet_a: assert property (o_sram.chip_sel_n |->
        o_sram.wr_en_n && o_sram.out_en_n && !o_data_pins_oe)
        else $error("strobes while deselected");
    rsp_pulse_a: assert property ($rose(o_rsp_valid) |->
        o_req_ready ##1 !o_rsp_valid) else $error("bad response pulse");
endmodule : asc_ctrl_props

// *** test/asc_sram_model.sv ***
// Behavioural 2k x 8 static memory on the controller's far side
`timescale 1ns/1ps
module asc_sram_model (
    // Memory pins
    input  wire logic                       i_low_supply,
    input  wire asc_pkg::asc_pins_t         i_sram,
    input  wire logic [asc_pkg::DATA_W-1:0] i_bus,
    output logic      [asc_pkg::DATA_W-1:0] o_dq,
    output logic                            o_dq_oe
);
    logic [asc_pkg::DATA_W-1:0] mem [asc_pkg::WORDS];
    logic [asc_pkg::DATA_W-1:0] fast;
    logic [asc_pkg::DATA_W-1:0] slow;
    logic [asc_pkg::DATA_W-1:0] last = 8'h00;
    wire logic rd_sel = !i_sram.chip_sel_n && !i_sram.out_en_n &&
        i_sram.wr_en_n;
    wire logic wr_stb_n = i_sram.chip_sel_n | i_sram.wr_en_n;
    // Old word stands until the access time runs out
    assign #99 fast = mem[i_sram.word_address];
    assign #249 slow = mem[i_sram.word_address];
    // Quiet unless reading; turn-on and float after a delay
    assign #5 o_dq_oe = rd_sel;
    assign o_dq = o_dq_oe ? (i_low_supply ? slow : fast) : ~last;
    always @(o_dq_oe or fast or slow) if (o_dq_oe) last = i_low_supply ? slow : fast;
    initial for (int i = 0; i < asc_pkg::WORDS; i++) mem[i] = 8'h00;
    // Capture at the first rising strobe
    always @(posedge wr_stb_n) mem[i_sram.word_address] = i_bus;
endmodule : asc_sram_model

// *** test/tb_top.sv ***
// Self-checking bench for the memory controller
`timescale 1ns/1ps
module tb_top;
    logic                       i_core_clk   = 1'b0;
    logic                       i_sys_rst    = 1'b1;
    logic                       i_req_valid  = 1'b0;
    asc_pkg::asc_req_t          i_req        = '0;
    logic                       i_retain_req = 1'b0;
    logic                       o_req_ready;
    logic                       o_rsp_valid;
    logic                       o_retain_ok;
    logic                       o_data_pins_oe;
    logic                       mem_oe;
    logic [asc_pkg::DATA_W-1:0] o_rsp_rdata;
    logic [asc_pkg::DATA_W-1:0] o_data_pins;
    logic [asc_pkg::DATA_W-1:0] mem_dq;
    logic [asc_pkg::DATA_W-1:0] bus;
    logic [asc_pkg::DATA_W-1:0] shadow [asc_pkg::WORDS];
    asc_pkg::asc_pins_t         o_sram;
    int                         error_cnt = 0;
    int                         tests_run = 0;
    int                         cycles    = 0;
    always #10 i_core_clk = ~i_core_clk;
    assign bus = o_data_pins_oe ? o_data_pins : mem_dq;
    asc_ctrl dut (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
        .i_req_valid(i_req_valid), .i_req(i_req), .o_req_ready(o_req_ready),
        .o_rsp_valid(o_rsp_valid), .o_rsp_rdata(o_rsp_rdata),
        .i_retain_req(i_retain_req), .o_retain_ok(o_retain_ok),
        .o_sram(o_sram), .i_data_pins(bus), .o_data_pins(o_data_pins),
        .o_data_pins_oe(o_data_pins_oe));
    asc_sram_model mem_model (.i_low_supply(i_req.low_supply),
        .i_sram(o_sram), .i_bus(bus), .o_dq(mem_dq), .o_dq_oe(mem_oe));
    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %0h seen %0h", what, exp, got);
        end
    endtask : check
    // One access, taken when ready; returns in the response cycle
    task automatic access(input logic wr, input logic low,
                          input logic [10:0] a, input logic [7:0] d);
        int k;
        int lat;
        k = 0;
        i_req = '{write: wr, low_supply: low, word_address: a, wdata: d};
        i_req_valid = 1'b1;
        while (o_req_ready !== 1'b1 && k < 40) begin
            @(negedge i_core_clk);
            k++;
        end
        @(negedge i_core_clk);
        i_req_valid = 1'b0;
        k = 0;
        while (o_rsp_valid !== 1'b1 && k < 40) begin
            @(negedge i_core_clk);
            k++;
        end
        // Write: setup, pulse, recovery, response; read: access, float
        lat = wr ? 3 + (low ? asc_pkg::WP_3V_CYC + asc_pkg::WR_3V_CYC
                            : asc_pkg::WP_5V_CYC + asc_pkg::WR_5V_CYC)
                 : 2 + (low ? asc_pkg::ACC_3V_CYC + asc_pkg::FLOAT_3V_CYC
                            : asc_pkg::ACC_5V_CYC + asc_pkg::FLOAT_5V_CYC);
        check("latency", lat, k);
        if (wr) shadow[a] = d;
        else check("rdata", shadow[a], o_rsp_rdata);
    endtask : access
    task automatic t_reset;
        check("pins", 14'h3800, o_sram);
        check("data_oe", 1'b0, o_data_pins_oe);
        check("ready", 1'b1, o_req_ready);
        $display("t_reset done");
    endtask : t_reset
    task automatic t_rw5;
        logic [10:0] adr [3] = '{11'h000, 11'h7FF, 11'h2AA};
        for (int i = 0; i < 3; i++) begin
            access(1'b1, 1'b0, adr[i], 8'hC3 ^ 8'(i));
        end
        for (int i = 0; i < 3; i++) begin
            access(1'b0, 1'b0, adr[i], 8'h00);
        end
        $display("t_rw5 done");
    endtask : t_rw5
    task automatic t_rw3;
        access(1'b1, 1'b1, 11'h123, 8'h5A);
        access(1'b1, 1'b1, 11'h456, 8'hA5);
        access(1'b0, 1'b1, 11'h123, 8'h00);
        access(1'b0, 1'b1, 11'h456, 8'h00);
        $display("t_rw3 done");
    endtask : t_rw3
    task automatic t_retain;
        int k;
        k = 0;
        i_retain_req = 1'b1;
        i_req_valid = 1'b1;
        while (o_retain_ok !== 1'b1 && k < 10) begin
            @(negedge i_core_clk);
            k++;
        end
        repeat (3) @(negedge i_core_clk);
        check("retain_ok", 1'b1, o_retain_ok);
        check("sel_n", 1'b1, o_sram.chip_sel_n);
        check("ready", 1'b0, o_req_ready);
        i_retain_req = 1'b0;
        i_req_valid = 1'b0;
        @(negedge i_core_clk);
        access(1'b0, 1'b0, 11'h7FF, 8'h00);
        $display("t_retain done");
    endtask : t_retain
    task automatic final_report;
        $display("tests_run=%0d error_cnt=%0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : final_report
    // Host and memory must never drive the data pins together
    always @(negedge i_core_clk) begin
        if (!i_sys_rst && mem_oe === 1'b1 &&
            o_data_pins_oe === 1'b1) begin
            error_cnt++;
            $display("Error contention expected 0 seen 1");
        end
    end
    always @(posedge i_core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            error_cnt++;
            final_report();
        end
    end
    initial begin
        repeat (12) @(posedge i_core_clk);
        @(negedge i_core_clk);
        i_sys_rst = 1'b0;
        @(negedge i_core_clk);
        t_reset();
        t_rw5();
        t_rw3();
        t_retain();
        final_report();
    end
endmodule : tb_top
bind asc_ctrl asc_ctrl_props u_props (.i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst), .o_req_ready(o_req_ready),
    .o_rsp_valid(o_rsp_valid), .o_retain_ok(o_retain_ok), .o_sram(o_sram),
    .o_data_pins(o_data_pins), .o_data_pins_oe(o_data_pins_oe));
